// File: src/embedded_control_core.sv
`timescale 1ns/100ps
`default_nettype none
module embedded_control_core import core_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             host_core_enable,
  input  wire logic             host_iram_we,
  input  wire logic [PAW-1:0]   host_iram_addr,
  input  wire logic [IW-1:0]    host_iram_wdata,
  input  wire logic [IRQ_N-1:1] irq_req,
  output logic                  irq_ack,
  output logic      [4:0]       irq_ack_id,
  output logic                  xdram_req,
  output logic                  xdram_we,
  output logic      [DAW-1:0]   xdram_addr,
  output logic      [DW-1:0]    xdram_wdata,
  input  wire logic             xdram_ack,
  input  wire logic [DW-1:0]    xdram_rdata,
  output logic                  ireg_req,
  output logic                  ireg_we,
  output logic      [8:0]       ireg_addr,
  output logic      [DW-1:0]    ireg_wdata,
  input  wire logic             ireg_ack,
  input  wire logic [DW-1:0]    ireg_rdata,
  input  wire logic             auto_boot_select_n,
  input  wire logic [7:0]       side_bus_data_in,
  output logic      [7:0]       side_bus_data_out,
  output logic                  side_bus_data_oe,
  output logic      [BOOT_AW-1:0] side_bus_address,
  output logic                  side_bus_io_read_n,
  output logic                  side_bus_io_write_n,
  output logic                  boot_rom_chip_select_n,
  output logic                  core_running
);
  typedef struct packed {
    logic             run;
    logic [PAW-1:0]   pc;
    logic             dv;
    logic [IW-1:0]    dir;
    logic             ev;
    op_type           eop;
    logic [4:0]       erd;
    logic [DW-1:0]    ea;
    logic [DW-1:0]    eb;
    logic [PAW-1:0]   eimm;
    logic             wv;
    logic [4:0]       wrd;
    logic [DW-1:0]    wval;
    logic [4:0]       seg;
    logic             ie;
    logic [PAW-1:0]   ret_pc;
    logic             mreq;
    region_type       mrgn;
    logic             mwe;
    logic [DAW-1:0]   maddr;
    logic [DW-1:0]    mwdata;
    logic             ack;
    logic [4:0]       ack_id;
  } core_state_type;

  core_state_type cur_ff;
  core_state_type nxt_ff;

  logic [IW-1:0]  iram [IRAM_DEPTH];
  logic [DW-1:0]  lram [LRAM_DEPTH];
  logic [DW-1:0]  regfile [RF_DEPTH];

  logic           boot_done;
  logic           load_we;
  logic [PAW-1:0] load_addr;
  logic [IW-1:0]  load_data;

  op_type         d_op;
  logic [4:0]     sa;
  logic [4:0]     sb;
  logic [DW-1:0]  va;
  logic [DW-1:0]  vb;
  logic           hazard;
  logic           d_ctrl;
  logic [DAW-1:0] e_addr;
  region_type     e_rgn;
  logic           e_mem;
  logic           m_ack;
  logic           mem_wait;
  logic [DW-1:0]  result;
  logic [31:0]    product;
  logic           redirect;
  logic [PAW-1:0] target;
  logic           irq_take;
  logic [4:0]     irq_id;
  logic           lram_we;

  boot_loader loader (
    .clk                    (clk),
    .rst_b                  (rst_b),
    .auto_boot_select_n     (auto_boot_select_n),
    .side_bus_data_in       (side_bus_data_in),
    .side_bus_data_out      (side_bus_data_out),
    .side_bus_data_oe       (side_bus_data_oe),
    .side_bus_address       (side_bus_address),
    .side_bus_io_read_n     (side_bus_io_read_n),
    .side_bus_io_write_n    (side_bus_io_write_n),
    .boot_rom_chip_select_n (boot_rom_chip_select_n),
    .load_we                (load_we),
    .load_addr              (load_addr),
    .load_data              (load_data),
    .boot_done              (boot_done)
  );

  // Register read with write-back bypass; index zero is hard zero
  function automatic logic [DW-1:0] rf_read(input logic [4:0] idx);
    if (idx == 5'h00) begin
      return '0;
    end else if (cur_ff.wv && cur_ff.wrd == idx) begin
      return cur_ff.wval;
    end
    return regfile[idx];
  endfunction

  // Lowest pending source wins the vector
  function automatic logic [4:0] irq_pick(input logic [IRQ_N-1:1] req);
    logic [4:0] id;
    id = 5'h00;
    for (int i = IRQ_N - 1; i >= 1; i--) begin
      if (req[i]) begin
        id = 5'(i);
      end
    end
    return id;
  endfunction

  // Pipeline next state
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = 1'b0;
    nxt_ff.wv  = 1'b0;
    d_op = op_type'(cur_ff.dir[OPC_LO +: 4]);
    sa = (d_op == OP_BZ) ? cur_ff.dir[RD_LO +: 5] : cur_ff.dir[RS1_LO +: 5];
    sb = (d_op == OP_ST) ? cur_ff.dir[RD_LO +: 5] : cur_ff.dir[RS2_LO +: 5];
    va = rf_read(sa);
    vb = rf_read(sb);
    d_ctrl = d_op inside {OP_JMP, OP_BZ, OP_RET};
    // Interlock instead of forwarding from execute; costs one bubble
    hazard = cur_ff.dv && cur_ff.ev && writes_rd(cur_ff.eop) && cur_ff.erd != 5'h00
             && (cur_ff.erd == sa || cur_ff.erd == sb);
    e_addr = {cur_ff.seg, cur_ff.ea};
    e_rgn = region_of(e_addr);
    e_mem = cur_ff.ev && (cur_ff.eop == OP_LD || cur_ff.eop == OP_ST);
    m_ack = (cur_ff.mrgn == RGN_XDRAM) ? xdram_ack : ireg_ack;
    mem_wait = e_mem && e_rgn != RGN_LRAM && !(cur_ff.mreq && m_ack);
    lram_we = 1'b0;
    product = cur_ff.ea * cur_ff.eb;
    // ALU; divide by zero gives all ones
    case (cur_ff.eop)
      OP_ADD:  result = cur_ff.ea + cur_ff.eb;
      OP_SUB:  result = cur_ff.ea - cur_ff.eb;
      OP_AND:  result = cur_ff.ea & cur_ff.eb;
      OP_OR:   result = cur_ff.ea | cur_ff.eb;
      OP_XOR:  result = cur_ff.ea ^ cur_ff.eb;
      OP_MUL:  result = product[15:0];
      OP_DIV:  result = (cur_ff.eb == '0) ? 16'hffff : cur_ff.ea / cur_ff.eb;
      OP_LDI:  result = {3'h0, cur_ff.eimm};
      OP_LD:   result = (e_rgn == RGN_LRAM) ? lram[e_addr[LRAM_AW-1:0]]
                        : (cur_ff.mrgn == RGN_XDRAM ? xdram_rdata : ireg_rdata);
      default: result = '0;
    endcase
    redirect = cur_ff.ev && (cur_ff.eop == OP_JMP || cur_ff.eop == OP_RET
               || (cur_ff.eop == OP_BZ && cur_ff.ea == '0));
    target = (cur_ff.eop == OP_RET) ? cur_ff.ret_pc : cur_ff.eimm;
    irq_id = irq_pick(irq_req);
    irq_take = 1'b0;
    // run only after firmware is in place
    nxt_ff.run = host_core_enable && boot_done;
    if (!cur_ff.run) begin
      // parked on the boot vector while stopped
      nxt_ff.pc   = BOOT_VEC;
      nxt_ff.dv   = 1'b0;
      nxt_ff.ev   = 1'b0;
      nxt_ff.mreq = 1'b0;
      nxt_ff.ie   = 1'b0;
    end else if (mem_wait) begin
      // Issue one request and hold every stage but write-back until it is answered
      if (!cur_ff.mreq) begin
        nxt_ff.mreq   = 1'b1;
        nxt_ff.mrgn   = e_rgn;
        nxt_ff.mwe    = cur_ff.eop == OP_ST;
        nxt_ff.maddr  = e_addr;
        nxt_ff.mwdata = cur_ff.eb;
      end
    end else begin
      nxt_ff.mreq = 1'b0;
      nxt_ff.wv   = cur_ff.ev && writes_rd(cur_ff.eop);
      nxt_ff.wrd  = cur_ff.erd;
      nxt_ff.wval = result;
      lram_we = e_mem && e_rgn == RGN_LRAM && cur_ff.eop == OP_ST;
      if (cur_ff.ev && cur_ff.eop == OP_SEGS) begin
        nxt_ff.seg = cur_ff.eimm[4:0];
      end
      if (cur_ff.ev && cur_ff.eop == OP_EI) begin
        nxt_ff.ie = 1'b1;
      end
      if (redirect) begin
        nxt_ff.ev = 1'b0;
        nxt_ff.dv = 1'b0;
        nxt_ff.pc = target;
      end else if (hazard) begin
        nxt_ff.ev = 1'b0;
      end else begin
        nxt_ff.ev   = cur_ff.dv;
        nxt_ff.eop  = d_op;
        nxt_ff.erd  = cur_ff.dir[RD_LO +: 5];
        nxt_ff.ea   = va;
        nxt_ff.eb   = vb;
        nxt_ff.eimm = cur_ff.dir[PAW-1:0];
        // jump to the source's vector, fetch address saved
        if (cur_ff.ie && irq_id != 5'h00 && !(cur_ff.dv && d_ctrl)) begin
          irq_take      = 1'b1;
          nxt_ff.ie     = 1'b0;
          nxt_ff.ret_pc = cur_ff.pc;
          nxt_ff.pc     = {8'h00, irq_id};
          nxt_ff.dv     = 1'b0;
          nxt_ff.ack    = 1'b1;
          nxt_ff.ack_id = irq_id;
        end else begin
          nxt_ff.dv  = 1'b1;
          nxt_ff.dir = (cur_ff.pc < PAW'(IRAM_DEPTH)) ? iram[cur_ff.pc] : '0;
          nxt_ff.pc  = cur_ff.pc + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // storage writes; register zero never stored
  always_ff @(posedge clk) begin
    if (load_we) begin
      iram[load_addr] <= load_data;
    end else if (boot_done && host_iram_we && host_iram_addr < PAW'(IRAM_DEPTH)) begin
      iram[host_iram_addr] <= host_iram_wdata;
    end
    if (lram_we) begin
      lram[e_addr[LRAM_AW-1:0]] <= cur_ff.eb;
    end
    if (cur_ff.wv && cur_ff.wrd != 5'h00) begin
      regfile[cur_ff.wrd] <= cur_ff.wval;
    end
  end

  // Outward ports of the data path
  assign xdram_req    = cur_ff.mreq && cur_ff.mrgn == RGN_XDRAM;
  assign xdram_we     = cur_ff.mwe;
  assign xdram_addr   = cur_ff.maddr;
  assign xdram_wdata  = cur_ff.mwdata;
  assign ireg_req     = cur_ff.mreq && cur_ff.mrgn == RGN_REGS;
  assign ireg_we      = cur_ff.mwe;
  assign ireg_addr    = cur_ff.maddr[8:0];
  assign ireg_wdata   = cur_ff.mwdata;
  assign irq_ack      = cur_ff.ack;
  assign irq_ack_id   = cur_ff.ack_id;
  assign core_running = cur_ff.run;

  pipe_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur_ff.wv |-> $past(cur_ff.ev) && $past(cur_ff.run))
    else $error("write-back without execute");
  zero_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cur_ff.dv && sa == 5'h00) |-> va == 16'h0000)
    else $error("register zero read nonzero");
  boot_vector_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cur_ff.run) |-> cur_ff.pc == BOOT_VEC && !cur_ff.dv)
    else $error("start not from location zero");
  irq_vector_a: assert property (@(posedge clk) disable iff (!rst_b)
    irq_take |=> cur_ff.pc == {8'h00, $past(irq_id)} && irq_ack && !cur_ff.ie)
    else $error("interrupt vector wrong");
  reg_window_a: assert property (@(posedge clk) disable iff (!rst_b)
    ireg_req |-> cur_ff.maddr <= REG_SPACE_LAST)
    else $error("register access out of window");
  lram_local_a: assert property (@(posedge clk) disable iff (!rst_b)
    (e_mem && e_rgn == RGN_LRAM) |-> !xdram_req && !ireg_req)
    else $error("local ram access left the core");
  dram_floor_a: assert property (@(posedge clk) disable iff (!rst_b)
    xdram_req |-> xdram_addr >= XDRAM_FIRST)
    else $error("low address sent to dram");
  seg_compose_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cur_ff.mreq) |-> cur_ff.maddr == {$past(cur_ff.seg), $past(cur_ff.ea)})
    else $error("data address not segment over register");
  boot_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !boot_done |=> !cur_ff.run)
    else $error("core ran before firmware load");
endmodule
`default_nettype wire

// File: pkg/core_pkg.sv
`default_nettype none
package core_pkg;
  // Storage geometry
  localparam int IRAM_DEPTH = 4608;
  localparam int IW         = 22;
  localparam int PAW        = 13;
  localparam int DW         = 16;
  localparam int DAW        = 21;
  localparam int RF_DEPTH   = 32;
  localparam int LRAM_DEPTH = 512;
  localparam int LRAM_AW    = 9;
  localparam int IRQ_N      = 32;

  // Program and data maps
  localparam logic [PAW-1:0] BOOT_VEC       = 13'h0000;
  localparam logic [DAW-1:0] REG_SPACE_LAST = 21'h0001ff;
  localparam logic [DAW-1:0] LRAM_FIRST     = 21'h000200;
  localparam logic [DAW-1:0] LRAM_LAST      = 21'h0003ff;
  localparam logic [DAW-1:0] XDRAM_FIRST    = 21'h000400;

  // Instruction fields
  localparam int OPC_LO = 18;
  localparam int RD_LO  = 13;
  localparam int RS1_LO = 8;
  localparam int RS2_LO = 3;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MUL, OP_DIV,
    OP_LDI, OP_LD, OP_ST, OP_SEGS, OP_JMP, OP_BZ, OP_RET, OP_EI
  } op_type;

  typedef enum logic [1:0] {RGN_REGS, RGN_LRAM, RGN_XDRAM} region_type;

  // Boot ROM side bus timing
  localparam int BOOT_AW     = 16;
  localparam int CLK_NS      = 4;
  localparam int STROBE_NS   = 120;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CW   = 6;

  // Data address decode
  function automatic region_type region_of(input logic [DAW-1:0] a);
    if (a <= REG_SPACE_LAST) begin
      return RGN_REGS;
    end else if (a <= LRAM_LAST) begin
      return RGN_LRAM;
    end
    return RGN_XDRAM;
  endfunction

  // Ops that leave a result in a general register
  function automatic logic writes_rd(input op_type op);
    return (op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MUL, OP_DIV, OP_LDI, OP_LD});
  endfunction
endpackage
`default_nettype wire

// File: src/boot_loader.sv
`timescale 1ns/100ps
`default_nettype none
module boot_loader import core_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             auto_boot_select_n,
  input  wire logic [7:0]       side_bus_data_in,
  output logic      [7:0]       side_bus_data_out,
  output logic                  side_bus_data_oe,
  output logic      [BOOT_AW-1:0] side_bus_address,
  output logic                  side_bus_io_read_n,
  output logic                  side_bus_io_write_n,
  output logic                  boot_rom_chip_select_n,
  output logic                  load_we,
  output logic      [PAW-1:0]   load_addr,
  output logic      [IW-1:0]    load_data,
  output logic                  boot_done
);
  typedef enum logic [2:0] {LD_SAMPLE, LD_SETUP, LD_STROBE, LD_WRITE, LD_DONE} load_phase_type;

  typedef struct packed {
    load_phase_type       phase;
    logic                 cs_n;
    logic                 rd_n;
    logic [BOOT_AW-1:0]   addr;
    logic [STROBE_CW-1:0] cnt;
    logic [1:0]           sel;
    logic [PAW-1:0]       word;
    logic [IW-1:0]        acc;
    logic                 we;
    logic                 done;
  } load_state_type;

  load_state_type cur_ff;
  load_state_type nxt_ff;
  logic [STROBE_CW-1:0] low_cnt_ff;

  // Byte sequencer; the strap is sampled only once, on the first edge after reset
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.we = 1'b0;
    case (cur_ff.phase)
      LD_SAMPLE: begin
        if (!auto_boot_select_n) begin
          nxt_ff.phase = LD_SETUP;
          nxt_ff.cs_n  = 1'b0;
        end else begin
          nxt_ff.phase = LD_DONE;
          nxt_ff.done  = 1'b1;
        end
      end
      LD_SETUP: begin
        nxt_ff.phase = LD_STROBE;
        nxt_ff.rd_n  = 1'b0;
        nxt_ff.cnt   = STROBE_CW'(STROBE_CYC - 1);
      end
      LD_STROBE: begin
        if (cur_ff.cnt != '0) begin
          nxt_ff.cnt = cur_ff.cnt - 1'b1;
        end else begin
          nxt_ff.rd_n = 1'b1;
          nxt_ff.addr = cur_ff.addr + 1'b1;
          case (cur_ff.sel)
            2'h0:    nxt_ff.acc[7:0]   = side_bus_data_in;
            2'h1:    nxt_ff.acc[15:8]  = side_bus_data_in;
            default: nxt_ff.acc[21:16] = side_bus_data_in[5:0];
          endcase
          if (cur_ff.sel == 2'h2) begin
            nxt_ff.sel   = 2'h0;
            nxt_ff.phase = LD_WRITE;
            nxt_ff.we    = 1'b1;
          end else begin
            nxt_ff.sel   = cur_ff.sel + 1'b1;
            nxt_ff.phase = LD_SETUP;
          end
        end
      end
      LD_WRITE: begin
        nxt_ff.word = cur_ff.word + 1'b1;
        if (cur_ff.word == PAW'(IRAM_DEPTH - 1)) begin
          nxt_ff.phase = LD_DONE;
          nxt_ff.done  = 1'b1;
          nxt_ff.cs_n  = 1'b1;
        end else begin
          nxt_ff.phase = LD_SETUP;
        end
      end
      LD_DONE: nxt_ff.phase = LD_DONE;
      default: nxt_ff.phase = LD_DONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff      <= '0;
      cur_ff.cs_n <= 1'b1;
      cur_ff.rd_n <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Helper: length of the current read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= cur_ff.rd_n ? '0 : low_cnt_ff + 1'b1;
    end
  end

  // side bus drive; ROM is never written
  assign boot_rom_chip_select_n = cur_ff.cs_n;
  assign side_bus_io_read_n     = cur_ff.rd_n;
  assign side_bus_io_write_n    = 1'b1;
  assign side_bus_address       = cur_ff.addr;
  assign side_bus_data_out      = 8'h00;
  assign side_bus_data_oe       = 1'b0;
  assign load_we                = cur_ff.we;
  assign load_addr              = cur_ff.word;
  assign load_data              = cur_ff.acc;
  assign boot_done              = cur_ff.done;

  strap_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cur_ff.phase == LD_SAMPLE && !auto_boot_select_n) |=> !cur_ff.cs_n)
    else $error("boot load did not start on strap");
  read_select_a: assert property (@(posedge clk) disable iff (!rst_b)
    !side_bus_io_read_n |-> !boot_rom_chip_select_n && !boot_done)
    else $error("read strobe without rom select");
  strobe_width_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(side_bus_io_read_n) |-> low_cnt_ff == STROBE_CW'(STROBE_CYC))
    else $error("read strobe width wrong");
endmodule
`default_nettype wire

// File: test/far_side_models.sv
`timescale 1ns/100ps
`default_nettype none
// Boot ROM; a released bus shows the inverse of the last byte
module boot_rom_model import core_pkg::*; (
  input  wire logic               clk,
  input  wire logic               cs_n,
  input  wire logic               rd_n,
  input  wire logic [BOOT_AW-1:0] addr,
  output logic      [7:0]         data
);
  logic [7:0] last_ff = 8'h00;
  assign data = (!cs_n && !rd_n) ? addr[7:0] ^ 8'h3c : ~last_ff;
  always @(posedge clk) begin
    if (!cs_n && !rd_n) last_ff <= data;
  end
endmodule

// Data bus target; wait grows with the low address bits
module mem_responder import core_pkg::*; (
  input  wire logic           clk,
  input  wire logic           req,
  input  wire logic [DAW-1:0] addr,
  output logic                ack,
  output logic      [DW-1:0]  rdata
);
  logic [2:0]    wait_ff = 3'h0;
  logic [DW-1:0] last_ff = 16'h0000;
  initial begin
    ack = 1'b0;
    rdata = 16'h0000;
  end
  // One ack per request; data is valid in the ack cycle only
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~last_ff;
    if (req && !ack) begin
      if (wait_ff == {1'b0, addr[1:0]}) begin
        ack <= 1'b1;
        rdata <= addr[15:0] ^ 16'h5a5a;
        last_ff <= addr[15:0] ^ 16'h5a5a;
        wait_ff <= 3'h0;
      end else begin
        wait_ff <= wait_ff + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/tb_embedded_control_core.sv
`timescale 1ns/100ps
`default_nettype none
module tb_embedded_control_core import core_pkg::*; ;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               host_core_enable = 1'b0;
  logic               host_iram_we = 1'b0;
  logic [PAW-1:0]     host_iram_addr = 13'h0000;
  logic [IW-1:0]      host_iram_wdata = 22'h000000;
  logic [IRQ_N-1:1]   irq_req = 31'h00000000;
  logic               auto_boot_select_n = 1'b1;
  logic               irq_ack, xdram_req, xdram_we, xdram_ack, ireg_req, ireg_we, ireg_ack;
  logic [4:0]         irq_ack_id;
  logic [DAW-1:0]     xdram_addr;
  logic [DW-1:0]      xdram_wdata, xdram_rdata, ireg_wdata, ireg_rdata;
  logic [8:0]         ireg_addr;
  logic [7:0]         side_bus_data_in, side_bus_data_out;
  logic [BOOT_AW-1:0] side_bus_address;
  logic               side_bus_data_oe, side_bus_io_read_n, side_bus_io_write_n;
  logic               boot_rom_chip_select_n, core_running;
  logic [PAW-1:0]     pc;
  logic [38:0]        got;
  logic [38:0]        exp_list [64];
  int                 bad_count = 0;
  int                 checked = 0;
  int                 idx = 0;
  int                 n_exp = 0;
  int                 n_main = 0;

  always #2 clk = ~clk;

  embedded_control_core dut (
    .clk, .rst_b, .host_core_enable, .host_iram_we, .host_iram_addr, .host_iram_wdata,
    .irq_req, .irq_ack, .irq_ack_id, .xdram_req, .xdram_we, .xdram_addr, .xdram_wdata,
    .xdram_ack, .xdram_rdata, .ireg_req, .ireg_we, .ireg_addr, .ireg_wdata, .ireg_ack,
    .ireg_rdata, .auto_boot_select_n, .side_bus_data_in, .side_bus_data_out,
    .side_bus_data_oe, .side_bus_address, .side_bus_io_read_n, .side_bus_io_write_n,
    .boot_rom_chip_select_n, .core_running);
  mem_responder xmem (.clk, .req(xdram_req), .addr(xdram_addr), .ack(xdram_ack),
    .rdata(xdram_rdata));
  mem_responder imem (.clk, .req(ireg_req), .addr({12'h000, ireg_addr}), .ack(ireg_ack),
    .rdata(ireg_rdata));
  boot_rom_model rom (.clk, .cs_n(boot_rom_chip_select_n), .rd_n(side_bus_io_read_n),
    .addr(side_bus_address), .data(side_bus_data_in));

  task automatic cmp(input string what, input logic [38:0] e, input logic [38:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Each finished transfer must be the next one the program implies
  always @(posedge clk) begin
    if (xdram_req) cmp("dram floor", 1'b1, xdram_addr >= XDRAM_FIRST);
    cmp("write strobe", 1'b1, side_bus_io_write_n);
    cmp("data drive", 1'b0, side_bus_data_oe);
    cmp("data out", 8'h00, side_bus_data_out);
    if ((xdram_req && xdram_ack) || (ireg_req && ireg_ack)) begin
      got = xdram_req ? {1'b1, xdram_we, xdram_addr, xdram_wdata}
                      : {1'b0, ireg_we, 12'h000, ireg_addr, ireg_wdata};
      if (!got[37]) got[15:0] = 16'h0000;
      cmp("transfer", exp_list[idx], got);
      idx++;
    end
  end

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
  endtask

  // Bounded wait for the transfer count; running out ends the run
  task automatic wait_idx(input int n);
    for (int i = 0; i < 4000 && idx < n; i++) @(posedge clk);
    #1;
    if (idx < n) begin
      bad_count++;
      $display("MISMATCH transfers expected %0d seen %0d", n, idx);
      print_verdict();
    end
  endtask

  function automatic logic [IW-1:0] ins(input op_type op, input logic [4:0] rd,
                                        input logic [12:0] v);
    return {op, rd, v};
  endfunction

  task automatic put(input logic [IW-1:0] w);
    @(posedge clk);
    #1;
    host_iram_we = 1'b1;
    host_iram_addr = pc;
    host_iram_wdata = w;
    pc = pc + 13'h0001;
  endtask

  // Three NOPs after each word, so hazards never matter
  task automatic emit(input logic [IW-1:0] w);
    put(w);
    repeat (3) put(22'h000000);
  endtask

  task automatic xfer(input logic x, we, input logic [DAW-1:0] a, input logic [DW-1:0] d);
    exp_list[n_exp] = {x, we, a, d};
    n_exp++;
  endtask

  task automatic st(input logic [4:0] rd, rs, input logic x, input logic [DAW-1:0] a,
                    input logic [DW-1:0] d);
    emit(ins(OP_ST, rd, {rs, 8'h00}));
    xfer(x, 1'b1, a, d);
  endtask

  task automatic load_program();
    logic [DW-1:0] ae [5] = '{16'h0222, 16'hffdc, 16'h0023, 16'h01ff, 16'h01dc};
    op_type        ao [5] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};
    n_exp = 0;
    pc = 13'h0000;
    // boot slot and vector 5 jump, other slots idle
    for (int i = 0; i < 32; i++) begin
      put(i == 0 ? ins(OP_JMP, 5'h00, 13'h0020) : i == 5 ? ins(OP_JMP, 5'h00, 13'h0100) : 22'h0);
    end
    emit(ins(OP_SEGS, 5'h00, 13'h0000));
    emit(ins(OP_LDI, 5'h01, 13'h0123));
    emit(ins(OP_LDI, 5'h02, 13'h01ff));
    emit(ins(OP_LDI, 5'h03, 13'h0200));
    emit(ins(OP_LDI, 5'h05, 13'h0400));
    emit(ins(OP_LDI, 5'h06, 13'h00ff));
    emit(ins(OP_LDI, 5'h00, 13'h0005));
    // register space, local RAM store and load back
    st(5'h01, 5'h02, 1'b0, 21'h0001ff, 16'h0123);
    emit(ins(OP_ST, 5'h01, {5'h03, 8'h00}));
    emit(ins(OP_LD, 5'h04, {5'h03, 8'h00}));
    st(5'h04, 5'h02, 1'b0, 21'h0001ff, 16'h0123);
    // lowest DRAM word, register zero stays zero
    st(5'h00, 5'h05, 1'b1, 21'h000400, 16'h0000);
    // multiply, divide, divide by zero, then add, subtract and logic ops
    emit(ins(OP_MUL, 5'h07, {5'h06, 5'h06, 3'h0}));
    st(5'h07, 5'h05, 1'b1, 21'h000400, 16'hfe01);
    emit(ins(OP_DIV, 5'h08, {5'h07, 5'h06, 3'h0}));
    st(5'h08, 5'h05, 1'b1, 21'h000400, 16'h00ff);
    emit(ins(OP_DIV, 5'h09, {5'h07, 5'h00, 3'h0}));
    st(5'h09, 5'h05, 1'b1, 21'h000400, 16'hffff);
    for (int i = 0; i < 5; i++) begin
      emit(ins(ao[i], 5'h09, {5'h06, 5'h01, 3'h0}));
      st(5'h09, 5'h05, 1'b1, 21'h000400, ae[i]);
    end
    // DRAM read written back, top segment
    emit(ins(OP_LD, 5'h0a, {5'h05, 8'h00}));
    xfer(1'b1, 1'b0, 21'h000400, 16'h0000);
    st(5'h0a, 5'h02, 1'b0, 21'h0001ff, 16'h5e5a);
    emit(ins(OP_SEGS, 5'h00, 13'h001f));
    st(5'h02, 5'h02, 1'b1, 21'h1f01ff, 16'h01ff);
    emit(ins(OP_EI, 5'h00, 13'h0000));
    n_main = n_exp;
    emit(ins(OP_JMP, 5'h00, pc));
    pc = 13'h0100;
    emit(ins(OP_LDI, 5'h0c, 13'h0005));
    st(5'h0c, 5'h05, 1'b1, 21'h1f0400, 16'h0005);
    emit(ins(OP_JMP, 5'h00, pc));
    @(posedge clk);
    #1;
    host_iram_we = 1'b0;
  endtask

  // Strap low: first byte timing, core held, then abort by reset
  task automatic boot_abort();
    int n = 0;
    auto_boot_select_n = 1'b0;
    host_core_enable = 1'b1;
    do_reset();
    @(posedge clk);
    #1;
    cmp("rom select", 1'b0, boot_rom_chip_select_n);
    cmp("setup strobe", 1'b1, side_bus_io_read_n);
    cmp("first address", 16'h0000, side_bus_address);
    @(posedge clk);
    #1;
    while (n < 40 && side_bus_io_read_n === 1'b0 && side_bus_address === 16'h0000) begin
      n++;
      @(posedge clk);
      #1;
    end
    cmp("strobe length", STROBE_CYC, n);
    cmp("next address", 16'h0001, side_bus_address);
    cmp("core held", 1'b0, core_running);
    rst_b = 1'b0;
    #1;
    cmp("select freed", 1'b1, boot_rom_chip_select_n);
  endtask

  // Host load, enable, full program run
  task automatic host_boot();
    auto_boot_select_n = 1'b1;
    host_core_enable = 1'b0;
    do_reset();
    load_program();
    host_core_enable = 1'b1;
    @(posedge clk);
    #1;
    cmp("running", 1'b1, core_running);
    wait_idx(n_main);
  endtask

  // Level request on vector 5 reaches its slot and routine
  task automatic irq_check();
    irq_req[5] = 1'b1;
    for (int i = 0; i < 200 && irq_ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("irq ack", 1'b1, irq_ack);
    cmp("irq id", 5'h05, irq_ack_id);
    irq_req[5] = 1'b0;
    wait_idx(n_main + 1);
  endtask

  // Second enable restarts at location zero, no extra traffic
  task automatic reenable();
    host_core_enable = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp("stopped", 1'b0, core_running);
    idx = 0;
    host_core_enable = 1'b1;
    wait_idx(n_main);
    repeat (60) @(posedge clk);
    #1;
    cmp("extra traffic", n_main, idx);
  endtask

  initial begin
    boot_abort();
    host_boot();
    irq_check();
    reenable();
    print_verdict();
  end
endmodule
`default_nettype wire
